// *** rtl/ocf_fault_response.sv ***
// Output over-current protection: limit, response byte, restart sequencing, host commands
//
// Operation
// - A 16-bit current fault threshold is written and read under command code 0x46.
// - Every over-current detected while the output is enabled sets the fault status bit and raises the host alert.
// - Response 00 keeps running and limits current at the threshold for as long as it lasts.
// - Response 01 limits current until the output falls below the floor, then shuts down.
// - Response 10 limits for the delay time, then shuts down if still limiting.
// - Response 11 disables the output at once and follows the retry setting.
// - The retry field gives the number of restart attempts after a shutdown by this fault.
// - Retry code 000 makes no attempt and keeps the output off until the fault is cleared.
// - Codes 001 to 011 allow one to three attempts, after which the output stays off.
// - Restart attempts start one delay time apart, the delay count times the unit.
// - Retry code 111 keeps attempting restarts without limit.
// - The delay code is a power of two, 1 to 128 units, the unit set outside this block.
// - A fault is cleared by bit clear, clear-faults command, reset, off-then-on or bias loss.
// - Codes 100 to 110 allow four to six attempts; endless retry stops on off, bias or other fault.
// - A 16-bit output voltage floor is written and read under command code 0x48.
`timescale 1ns/100ps
module ocf_fault_response
  import ocf_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host command port, latched on the rising edge of cmdClk
  input wire logic cmdClk,
  input wire logic cmdSelect,
  input wire logic cmdRead,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdWrData,
  output logic [15:0] cmdRdData,
  // Analog comparators and control pins
  input wire logic ocDetect,
  input wire logic lowVoltage,
  input wire logic ctrlOn,
  input wire logic biasGood,
  input wire logic otherFault,
  // Same-domain configuration and status control
  input wire logic [15:0] delayUnitCycles,
  input wire logic faultBitClear,
  // Power stage and status
  output logic outputEnable,
  output logic currentLimit,
  output logic [15:0] thresholdLevel,
  output logic [15:0] voltageFloor,
  output logic ocFaultStatus,
  output logic hostAlert
);

  localparam int PIN_W = 32;

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinS1Q;
  logic [PIN_W-1:0] pinS2Q;
  logic cmdClkS;
  logic cmdSelS;
  logic cmdReadS;
  logic [7:0] cmdCodeS;
  logic [15:0] cmdDataS;
  logic ocDetectS;
  logic lowVoltageS;
  logic ctrlOnS;
  logic biasGoodS;
  logic otherFaultS;
  logic cmdClkPrevQ;
  logic cmdEdge;
  logic wrStrobe;
  logic rdStrobe;
  logic clearCmd;
  logic [15:0] thresholdQ;
  logic [7:0] actionQ;
  logic [15:0] floorQ;
  logic [15:0] rdDataQ;
  logic [15:0] rdMux;
  logic [1:0] respSel;
  logic [2:0] retrySel;
  logic runCmd;
  logic runPrevQ;
  logic onRise;
  logic clrEvent;
  ocf_state_t stateQ;
  ocf_state_t stateD;
  logic [2:0] retryQ;
  logic [2:0] retryEff;
  logic retryingQ;
  logic reloadEv;
  logic retryDec;
  logic restart;
  logic settled;
  logic canRetry;
  logic tStart;
  logic tAbort;
  logic faultQ;
  logic alertQ;
  logic outEnQ;
  logic limitQ;
  logic faultSet;

  ocf_timer_if tif ();

  ocf_delay_timer u_timer (
    .mclk(mclk),
    .reset(reset),
    .tif(tif)
  );

  // Every pin passes two flops before use; command data is stable long before the clock edge
  assign pinRaw = {cmdClk, cmdSelect, cmdRead, cmdCode, cmdWrData,
                   ocDetect, lowVoltage, ctrlOn, biasGood, otherFault};

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pinS1Q <= '0;
      pinS2Q <= '0;
    end
    else
    begin
      pinS1Q <= pinRaw;
      pinS2Q <= pinS1Q;
    end
  end

  // Synchronised pin decode
  assign cmdClkS = pinS2Q[31];
  assign cmdSelS = pinS2Q[30];
  assign cmdReadS = pinS2Q[29];
  assign cmdCodeS = pinS2Q[28:21];
  assign cmdDataS = pinS2Q[20:5];
  assign ocDetectS = pinS2Q[4];
  assign lowVoltageS = pinS2Q[3];
  assign ctrlOnS = pinS2Q[2];
  assign biasGoodS = pinS2Q[1];
  assign otherFaultS = pinS2Q[0];

  // Command strobes from the link clock's rising edge
  assign cmdEdge = cmdClkS && !cmdClkPrevQ;
  assign wrStrobe = cmdEdge && cmdSelS && !cmdReadS;
  assign rdStrobe = cmdEdge && cmdSelS && cmdReadS;
  assign clearCmd = wrStrobe && (cmdCodeS == CMD_CLEAR_FAULTS);

  // Read selection; unmapped codes read as zero
  assign rdMux = (cmdCodeS == CMD_OC_THRESHOLD) ? thresholdQ :
                 (cmdCodeS == CMD_OC_ACTION) ? {8'h00, actionQ} :
                 (cmdCodeS == CMD_OC_VFLOOR) ? floorQ :
                 READ_UNMAPPED;

  // Host-visible registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cmdClkPrevQ <= 1'b0;
      thresholdQ <= THRESHOLD_RESET;
      actionQ <= ACTION_RESET;
      floorQ <= VFLOOR_RESET;
      rdDataQ <= READ_UNMAPPED;
    end
    else
    begin
      cmdClkPrevQ <= cmdClkS;
      if (wrStrobe && (cmdCodeS == CMD_OC_THRESHOLD))
        thresholdQ <= cmdDataS;
      if (wrStrobe && (cmdCodeS == CMD_OC_ACTION))
        actionQ <= cmdDataS[7:0];
      if (wrStrobe && (cmdCodeS == CMD_OC_VFLOOR))
        floorQ <= cmdDataS;
      if (rdStrobe)
        rdDataQ <= rdMux;
    end
  end

  // Action byte fields
  assign respSel = actionQ[ACT_RESP_HI:ACT_RESP_LO];
  assign retrySel = actionQ[ACT_RETRY_HI:ACT_RETRY_LO];
  assign tif.code = actionQ[ACT_DELAY_HI:ACT_DELAY_LO];
  assign tif.unitCycles = delayUnitCycles;
  assign tif.start = tStart;
  assign tif.abort = tAbort;

  // Output commanded on only with bias present; off-then-on and bias loss clear the fault
  assign runCmd = ctrlOnS && biasGoodS;
  assign onRise = runCmd && !runPrevQ;
  assign clrEvent = faultBitClear || clearCmd || onRise || !biasGoodS;

  // A detection while no retry sequence is open is a new fault event
  assign retryEff = reloadEv ? retrySel : retryQ;
  assign canRetry = (retrySel == RETRY_CONTINUOUS) || (retryEff != RETRY_NONE);

  // Protection sequencing; a shutdown either waits for a restart or latches off
  always_comb
  begin
    stateD = stateQ;
    tStart = 1'b0;
    tAbort = 1'b0;
    reloadEv = 1'b0;
    retryDec = 1'b0;
    restart = 1'b0;
    settled = 1'b0;
    if (!runCmd)
    begin
      stateD = ST_OFF;
      tAbort = 1'b1;
    end
    else if (otherFaultS)
    begin
      stateD = ST_LATCH;
      tAbort = 1'b1;
    end
    else
    begin
      unique case (stateQ)
        ST_OFF:
          stateD = ST_RUN;
        ST_RUN:
          if (ocDetectS)
          begin
            reloadEv = !retryingQ;
            unique case (respSel)
              RESP_CONST_CURRENT, RESP_CONDITIONED:
                stateD = ST_LIMIT;
              RESP_DELAY_RETRY:
              begin
                stateD = ST_DELAY;
                tStart = 1'b1;
              end
              RESP_DISABLE_RETRY:
              begin
                stateD = canRetry ? ST_WAIT : ST_LATCH;
                tStart = canRetry;
              end
            endcase
          end
          else if (retryingQ && tif.done)
            settled = 1'b1;
        ST_LIMIT:
          if (!ocDetectS)
            stateD = ST_RUN;
          else if ((respSel == RESP_CONDITIONED) && lowVoltageS)
          begin
            stateD = canRetry ? ST_WAIT : ST_LATCH;
            tStart = canRetry;
          end
        ST_DELAY:
          if (!ocDetectS)
          begin
            stateD = ST_RUN;
            tAbort = 1'b1;
          end
          else if (tif.done)
          begin
            stateD = canRetry ? ST_WAIT : ST_LATCH;
            tStart = canRetry;
          end
        ST_WAIT:
          if (tif.done)
          begin
            stateD = ST_RUN;
            restart = 1'b1;
            retryDec = (retrySel != RETRY_CONTINUOUS);
            tStart = 1'b1;
          end
        ST_LATCH:
          if (clrEvent)
            stateD = ST_RUN;
        default:
          stateD = ST_OFF;
      endcase
    end
  end

  // Set wins over clear so a detection in the clearing cycle is kept
  assign faultSet = ocDetectS && outEnQ;

  // State, attempt counter and status flops
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      stateQ <= ST_OFF;
      runPrevQ <= 1'b0;
      retryQ <= RETRY_NONE;
      retryingQ <= 1'b0;
      faultQ <= 1'b0;
      alertQ <= 1'b0;
      outEnQ <= 1'b0;
      limitQ <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
      runPrevQ <= runCmd;
      if (clrEvent || reloadEv)
        retryQ <= retrySel;
      if (retryDec)
        retryQ <= retryEff - 3'h1;
      if (clrEvent || settled || !runCmd)
        retryingQ <= 1'b0;
      else if (restart)
        retryingQ <= 1'b1;
      faultQ <= faultSet || (faultQ && !clrEvent);
      alertQ <= faultSet || (alertQ && !clrEvent);
      outEnQ <= (stateD == ST_RUN) || (stateD == ST_LIMIT) || (stateD == ST_DELAY);
      limitQ <= (stateD == ST_LIMIT) || (stateD == ST_DELAY);
    end
  end

  // Outputs
  assign cmdRdData = rdDataQ;
  assign outputEnable = outEnQ;
  assign currentLimit = limitQ;
  assign thresholdLevel = thresholdQ;
  assign voltageFloor = floorQ;
  assign ocFaultStatus = faultQ;
  assign hostAlert = alertQ;

endmodule : ocf_fault_response

// *** rtl/ocf_pkg.sv ***
// Package of command codes, field layouts, reset values and states for over-current response
package ocf_pkg;

  // Command codes of the host command port
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OC_THRESHOLD = 8'h46;
  localparam logic [7:0] CMD_OC_ACTION = 8'h47;
  localparam logic [7:0] CMD_OC_VFLOOR = 8'h48;

  // Field layout of the action byte
  localparam int ACT_RESP_HI = 7;
  localparam int ACT_RESP_LO = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;

  // Response selector codes
  localparam logic [1:0] RESP_CONST_CURRENT = 2'h0;
  localparam logic [1:0] RESP_CONDITIONED = 2'h1;
  localparam logic [1:0] RESP_DELAY_RETRY = 2'h2;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h3;

  // Retry field codes
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_CONTINUOUS = 3'h7;

  // Reset values of the host-visible registers
  localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
  localparam logic [7:0] ACTION_RESET = 8'hC0;
  localparam logic [15:0] VFLOOR_RESET = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;

  // Protection state machine
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RUN = 3'b001,
    ST_LIMIT = 3'b010,
    ST_DELAY = 3'b011,
    ST_WAIT = 3'b100,
    ST_LATCH = 3'b101
  } ocf_state_t;

endpackage : ocf_pkg

// *** rtl/ocf_timer_if.sv ***
// Interface between the response state machine and its delay timer
`timescale 1ns/100ps
interface ocf_timer_if;
  logic start;
  logic abort;
  logic [2:0] code;
  logic [15:0] unitCycles;
  logic done;
  logic busy;

  modport ctrl (output start, abort, code, unitCycles, input done, busy);
  modport timer (input start, abort, code, unitCycles, output done, busy);
endinterface : ocf_timer_if

// *** rtl/ocf_delay_timer.sv ***
// Delay timer: counts 2**code delay units, each unit a number of mclk cycles
`timescale 1ns/100ps
module ocf_delay_timer
  import ocf_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control side
  ocf_timer_if.timer tif
);

  logic [15:0] preQ;
  logic [7:0] unitsQ;
  logic busyQ;
  logic doneQ;
  logic [15:0] unitLast;
  logic [7:0] unitsLast;
  logic unitTick;

  // A unit length of zero would never tick, so it counts as one cycle
  assign unitLast = (tif.unitCycles == 16'h0000) ? 16'h0000 : tif.unitCycles - 16'h0001;
  assign unitsLast = (8'h01 << tif.code) - 8'h01;
  assign unitTick = busyQ && (preQ == unitLast);
  assign tif.done = doneQ;
  assign tif.busy = busyQ;

  // Prescaler gives a one-cycle unit enable, units count to the decoded power of two
  always_ff @(posedge mclk)
  begin
    if (reset || tif.abort)
    begin
      preQ <= 16'h0000;
      unitsQ <= 8'h00;
      busyQ <= 1'b0;
      doneQ <= 1'b0;
    end
    else if (tif.start)
    begin
      preQ <= 16'h0000;
      unitsQ <= 8'h00;
      busyQ <= 1'b1;
      doneQ <= 1'b0;
    end
    else
    begin
      doneQ <= unitTick && (unitsQ == unitsLast);
      if (unitTick)
      begin
        preQ <= 16'h0000;
        unitsQ <= unitsQ + 8'h01;
        busyQ <= (unitsQ != unitsLast);
      end
      else if (busyQ)
      begin
        preQ <= preQ + 16'h0001;
      end
    end
  end

endmodule : ocf_delay_timer

// *** testbench/ocf_fault_response_chk.sv ***
// Port checker for the over-current response block
`timescale 1ns/100ps
module ocf_fault_response_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Watched inputs
  input wire logic cmdSelect,
  input wire logic cmdRead,
  input wire logic ocDetect,
  input wire logic ctrlOn,
  input wire logic biasGood,
  input wire logic otherFault,
  input wire logic faultBitClear,
  // Watched outputs
  input wire logic outputEnable,
  input wire logic currentLimit,
  input wire logic [15:0] thresholdLevel,
  input wire logic [15:0] voltageFloor,
  input wire logic ocFaultStatus,
  input wire logic hostAlert
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Pin effects pass two sync flops, so counts allow for that lag
  chk_alert_mirror: assert property (hostAlert == ocFaultStatus)
    else $error("alert differs from status");
  chk_fault_set: assert property ((ocDetect && outputEnable) [*4] |-> ##[0:2] ocFaultStatus)
    else $error("fault status not set");
  chk_reset_clear: assert property ($fell(reset) |-> !outputEnable && !ocFaultStatus)
    else $error("outputs live after reset");
  chk_power_off: assert property (!(ctrlOn && biasGood) [*4] |-> !outputEnable)
    else $error("output on while off or unbiased");
  chk_other_off: assert property (otherFault [*4] |-> !outputEnable)
    else $error("output on during other fault");
  chk_limit_drop: assert property (!ocDetect [*5] |-> !currentLimit)
    else $error("limit without over-current");
  chk_bit_clear: assert property (!ocDetect [*3] ##0 faultBitClear |=> !ocFaultStatus)
    else $error("status survived clear");
  chk_thr_write: assert property (!$stable(thresholdLevel) |-> $past(cmdSelect, 2) && !$past(cmdRead, 2))
    else $error("threshold changed without write");
  chk_floor_write: assert property (!$stable(voltageFloor) |-> $past(cmdSelect, 2) && !$past(cmdRead, 2))
    else $error("floor changed without write");
endmodule : ocf_fault_response_chk

// *** testbench/ocf_host_model.sv ***
// Host command model: one command per framed cmdClk period
`timescale 1ns/100ps
module ocf_host_model (
  // Clock
  mclk,
  // Command pins
  cmdClk,
  cmdSelect,
  cmdRead,
  cmdCode,
  cmdWrData
);
  input wire logic mclk;
  output logic cmdClk = 1'b0;
  output logic cmdSelect = 1'b0;
  output logic cmdRead = 1'b0;
  output logic [7:0] cmdCode = 8'h00;
  output logic [15:0] cmdWrData = 16'h0000;

  // Pins stand 400 ns before the rise and 800 ns after it; the clock idles low between frames
  task xfer(input logic rd, input logic [7:0] code, input logic [15:0] wd);
    @(posedge mclk);
    cmdSelect <= 1'b1;
    cmdRead <= rd;
    cmdCode <= code;
    cmdWrData <= wd;
    repeat (4) @(posedge mclk);
    cmdClk <= 1'b1;
    repeat (4) @(posedge mclk);
    cmdClk <= 1'b0;
    repeat (4) @(posedge mclk);
    // Released lines show the inverse so stale values never pass
    cmdSelect <= 1'b0;
    cmdRead <= ~rd;
    cmdCode <= ~code;
    cmdWrData <= ~wd;
  endtask : xfer
endmodule : ocf_host_model

// *** testbench/tb_ocf_fault_response.sv ***
// Self-checking bench for the over-current response block
`timescale 1ns/100ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin failures++; $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_ocf_fault_response
  import ocf_pkg::*;
;
  logic mclk, reset, cmdClk, cmdSelect, cmdRead, ocDetect, lowVoltage, ctrlOn, biasGood;
  logic otherFault, faultBitClear, outputEnable, currentLimit, ocFaultStatus, hostAlert, rdy, pe;
  logic [7:0] cmdCode;
  logic [15:0] cmdWrData, cmdRdData, delayUnitCycles, thresholdLevel, voltageFloor, obs, v, thr;
  logic [15:0] expQ[$];
  logic [2:0] dc;
  int failures, nTests, seed, cyc, n, gap, t0, e;

  ocf_host_model host_u (.mclk, .cmdClk, .cmdSelect, .cmdRead, .cmdCode, .cmdWrData);
  ocf_fault_response dut_u (.mclk, .reset, .cmdClk, .cmdSelect, .cmdRead, .cmdCode, .cmdWrData,
    .cmdRdData, .ocDetect, .lowVoltage, .ctrlOn, .biasGood, .otherFault, .delayUnitCycles,
    .faultBitClear, .outputEnable, .currentLimit, .thresholdLevel, .voltageFloor,
    .ocFaultStatus, .hostAlert);

  // Clock and cycle count
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // Compare each noted result with the oldest expectation
  always @(posedge mclk)
  begin
    if (rdy)
    begin
      v = expQ.pop_front();
      `CHK(obs, v)
    end
  end

  task note(input logic [15:0] x, input logic [15:0] a);
    expQ.push_back(x);
    obs <= a;
    rdy <= 1'b1;
    @(posedge mclk);
    rdy <= 1'b0;
    @(posedge mclk);
  endtask : note

  task rd(input logic [7:0] c, input logic [15:0] x);
    host_u.xfer(1'b1, c, 16'h0000);
    note(x, cmdRdData);
  endtask : rd

  task act(input logic [15:0] a);
    host_u.xfer(1'b0, CMD_OC_ACTION, a);
  endtask : act

  // Clear by one of four paths, then the output must run again
  task clr(input int how);
    ocDetect <= 1'b0;
    repeat (4) @(posedge mclk);
    case (how)
      0: faultBitClear <= 1'b1;
      1: host_u.xfer(1'b0, CMD_CLEAR_FAULTS, 16'h0000);
      2: ctrlOn <= 1'b0;
      default: biasGood <= 1'b0;
    endcase
    @(posedge mclk);
    faultBitClear <= 1'b0;
    repeat (8) @(posedge mclk);
    {ctrlOn, biasGood} <= 2'b11;
    repeat (12) @(posedge mclk);
    note(16'h0001, 16'({ocFaultStatus, outputEnable}));
  endtask : clr

  task stop_test();
    $display("Counts: %0d compared, %0d mismatched", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Watchdog sized well past the expected run of about 6700 cycles
  initial
  begin
    #3000000;
    failures++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    {reset, ocDetect, lowVoltage, ctrlOn, otherFault, faultBitClear, rdy} = 7'h40;
    biasGood = 1'b1;
    delayUnitCycles = 16'h0004;
    obs = 16'h0000;
    seed = 71946;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    note(16'h0000, 16'({outputEnable, currentLimit, ocFaultStatus, hostAlert}));
    rd(CMD_OC_ACTION, {8'h00, ACTION_RESET});
    rd(CMD_OC_VFLOOR, 16'h0000);
    rd(8'h5E, READ_UNMAPPED);
    thr = 16'($random(seed));
    host_u.xfer(1'b0, CMD_OC_THRESHOLD, thr);
    host_u.xfer(1'b0, CMD_OC_VFLOOR, ~thr);
    act({thr[15:8], RESP_CONST_CURRENT, 6'h00});
    rd(CMD_OC_THRESHOLD, thr);
    rd(CMD_OC_VFLOOR, ~thr);
    rd(CMD_OC_ACTION, 16'h0000);
    note(thr, thresholdLevel);
    note(~thr, voltageFloor);
    clr(2);
    $display("test registers done");
    // Constant current runs on, then other fault latches off
    ocDetect <= 1'b1;
    repeat (300) @(posedge mclk);
    note(16'h0003, 16'({outputEnable, currentLimit}));
    {ocDetect, otherFault} <= 2'b01;
    repeat (8) @(posedge mclk);
    otherFault <= 1'b0;
    repeat (8) @(posedge mclk);
    note(16'h0000, 16'({outputEnable, currentLimit}));
    clr(0);
    // Conditioned limit shuts down below the floor
    act({8'h00, RESP_CONDITIONED, 6'h00});
    ocDetect <= 1'b1;
    repeat (20) @(posedge mclk);
    note(16'h0003, 16'({outputEnable, currentLimit}));
    lowVoltage <= 1'b1;
    repeat (10) @(posedge mclk);
    note(16'h0000, 16'(outputEnable));
    lowVoltage <= 1'b0;
    clr(1);
    // Delayed limit: 16 cycles of limiting, then shutdown
    act({8'h00, RESP_DELAY_RETRY, 6'h02});
    ocDetect <= 1'b1;
    repeat (8) @(posedge mclk);
    note(16'h0003, 16'({outputEnable, currentLimit}));
    repeat (20) @(posedge mclk);
    note(16'h0000, 16'(outputEnable));
    clr(3);
    $display("test limiting done");
    // Every retry code with held over-current; delay code r mod 4, the longest code with one retry
    for (int r = 0; r < 8; r++)
    begin
      dc = (r == 1) ? 3'h7 : 3'(r % 4);
      act({8'hA5, RESP_DISABLE_RETRY, 3'(r), dc});
      e = (1 << dc) * 4;
      {n, gap, t0} = 0;
      pe = 1'b1;
      ocDetect <= 1'b1;
      repeat (700)
      begin
        @(posedge mclk);
        if (!outputEnable && pe) t0 = cyc;
        if (outputEnable && !pe)
        begin
          if (n == 0) gap = cyc - t0;
          n++;
        end
        pe = outputEnable;
      end
      note({2'b11, 14'(r == 7 ? 8 : r)},
           {ocFaultStatus, hostAlert, 14'(n > 7 ? 8 : n)});
      if (r > 0) note(16'h0001, 16'(gap >= e && gap <= e + 3));
      clr(r % 4);
    end
    $display("test retries done");
    stop_test();
  end
endmodule : tb_ocf_fault_response

bind ocf_fault_response ocf_fault_response_chk chk_u (.mclk, .reset, .cmdSelect, .cmdRead,
  .ocDetect, .ctrlOn, .biasGood, .otherFault, .faultBitClear, .outputEnable, .currentLimit,
  .thresholdLevel, .voltageFloor, .ocFaultStatus, .hostAlert);
